// File: rtl/phy_link_request_status.sv
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module phy_link_request_status (
   // Clock and reset
   input  wire logic                                 sys_clk_in,
   input  wire logic                                 rst_in,
   // APB slave
   input  wire logic [phy_link_pkg::APB_ADDR_W-1:0]  paddr_in,
   input  wire logic                                 psel_in,
   input  wire logic                                 penable_in,
   input  wire logic                                 pwrite_in,
   input  wire logic [31:0]                          pwdata_in,
   output logic [31:0]                               prdata_out,
   output logic                                      pready_out,
   output logic                                      pslverr_out,
   // Physical layer pins
   input  wire logic                                 link_clock_in,
   input  wire logic [1:0]                           control_pair_in,
   input  wire logic [1:0]                           low_data_lines_in,
   output logic                                      link_request_line_out,
   // Receive and transmit logic of this link
   input  wire logic                                 cycle_start_in,
   input  wire logic                                 ack_needed_in,
   input  wire logic                                 header_bad_in,
   output logic                                      bus_grant_out,
   output logic                                      tx_blocked_out
);
   import phy_link_pkg::*;

   typedef enum logic [1:0] {R_IDLE, R_WAIT_IDLE, R_SEND, R_WATCH} req_state_e;

   function automatic logic [4:0] len_for(input logic [2:0] t);
      if (t == TYPE_REG_R) return LEN_REG_R;
      if (t == TYPE_REG_W) return LEN_REG_W;
      return LEN_BUS;
   endfunction

   function automatic logic [FRAME_W-1:0] frame_for(input logic [2:0] t, input logic [1:0] s,
                                                     input logic [3:0] a, input logic [7:0] d);
      if (t == TYPE_REG_W) return {START_BIT, t, a, d, STOP_BIT};
      if (t == TYPE_REG_R) return {START_BIT, t, a, STOP_BIT, 8'h00};
      return {START_BIT, t, s, STOP_BIT, 10'h000};
   endfunction

   function automatic logic is_bus(input logic [2:0] t);
      return (t == TYPE_TAKE) || (t == TYPE_ISO) || (t == TYPE_PRI) || (t == TYPE_FAIR);
   endfunction

   function automatic logic [3:0] rev4(input logic [3:0] v);
      return {v[0], v[1], v[2], v[3]};
   endfunction

   // Synchronisers; the third stage holds the value from before the edge
   logic       sclk_s1, sclk_s2, sclk_d;
   logic [1:0] ctl_s1, ctl_s2, ctl_d;
   logic [1:0] dat_s1, dat_s2, dat_d;
   logic       tick;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_d  <= 1'b0;
         ctl_s1  <= CTL_IDLE;
         ctl_s2  <= CTL_IDLE;
         ctl_d   <= CTL_IDLE;
         dat_s1  <= 2'h0;
         dat_s2  <= 2'h0;
         dat_d   <= 2'h0;
      end else begin
         sclk_s1 <= link_clock_in;
         sclk_s2 <= sclk_s1;
         sclk_d  <= sclk_s2;
         ctl_s1  <= control_pair_in;
         ctl_s2  <= ctl_s1;
         ctl_d   <= ctl_s2;
         dat_s1  <= low_data_lines_in;
         dat_s2  <= dat_s1;
         dat_d   <= dat_s2;
      end
   end

   assign tick = sclk_s2 && !sclk_d;

   // Control state
   req_state_e state, next_state;
   logic [2:0] req_type, next_req_type;
   logic [1:0] req_speed, next_req_speed;
   logic [3:0] req_addr, next_req_addr;
   logic [7:0] req_data, next_req_data;
   logic [2:0] cur_type, next_cur_type;
   logic       cycle_seen, next_cycle_seen;
   logic       lost, next_lost;
   logic       refused, next_refused;
   logic       hdr_bad, next_hdr_bad;
   logic       idle_prev, next_idle_prev;
   logic [3:0] block_cnt, next_block_cnt;
   logic       next_bus_grant;
   logic [3:0] phy_status, next_phy_status;
   logic [3:0] rd_addr, next_rd_addr;
   logic [7:0] rd_data, next_rd_data;
   logic       rd_valid, next_rd_valid;
   logic [15:0] st_shift, next_st_shift;
   logic [3:0] st_cnt, next_st_cnt;
   logic [31:0] next_prdata;
   logic       next_pslverr;
   logic       shift_load;
   logic [2:0] load_type;
   logic       shift_busy, shift_done;
   logic       wr_go, req_go, mapped;
   logic [31:0] clr_bits, rd_mux;

   link_request_shifter link_request_shifter_inst (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .tick_in    (tick),
      .load_in    (shift_load),
      .frame_in   (frame_for(load_type, req_speed, req_addr, req_data)),
      .len_in     (len_for(load_type)),
      .line_out   (link_request_line_out),
      .busy_out   (shift_busy),
      .done_out   (shift_done)
   );

   always_comb begin
      wr_go    = psel_in && penable_in && pready_out && pwrite_in;
      req_go   = wr_go && (paddr_in == OFS_REQUEST);
      clr_bits = (wr_go && paddr_in == OFS_STATUS) ? pwdata_in : 32'h0000_0000;
      mapped   = (paddr_in == OFS_REQUEST) || (paddr_in == OFS_STATUS) ||
                 (paddr_in == OFS_PHY_STATUS) || (paddr_in == OFS_READ_DATA);
      case (paddr_in)
         OFS_REQUEST:    rd_mux = {8'h00, req_data, 4'h0, req_addr, 2'h0, req_speed, 1'b0, req_type};
         OFS_STATUS:     rd_mux = {27'h000_0000, rd_valid, cycle_seen, refused, lost, state != R_IDLE};
         OFS_PHY_STATUS: rd_mux = {28'h000_0000, phy_status};
         OFS_READ_DATA:  rd_mux = {20'h0_0000, rd_addr, rd_data};
         default:        rd_mux = 32'h0000_0000;
      endcase
      next_prdata  = (psel_in && !penable_in) ? rd_mux : prdata_out;
      next_pslverr = (psel_in && !penable_in) ? !mapped : pslverr_out;

      next_state      = state;
      next_req_type   = req_type;
      next_req_speed  = req_speed;
      next_req_addr   = req_addr;
      next_req_data   = req_data;
      next_cur_type   = cur_type;
      next_hdr_bad    = hdr_bad;
      next_idle_prev  = tick ? (ctl_d == CTL_IDLE) : idle_prev;
      next_block_cnt  = (block_cnt != 4'h0) ? block_cnt - 4'h1 : block_cnt;
      shift_load      = 1'b0;
      load_type       = cur_type;
      // Software clears first so that a same-cycle hardware set wins
      next_lost       = lost && !clr_bits[STB_LOST];
      next_refused    = refused && !clr_bits[STB_REFUSED];
      next_cycle_seen = cycle_seen && !clr_bits[STB_CYCLE];
      next_rd_valid   = rd_valid && !clr_bits[STB_RDVALID];

      case (state)
         R_IDLE: begin
            if (req_go) begin
               next_req_type  = pwdata_in[REQ_TYPE_LSB +: 3];
               next_req_speed = pwdata_in[REQ_SPEED_LSB +: 2];
               next_req_addr  = pwdata_in[REQ_ADDR_LSB +: 4];
               next_req_data  = pwdata_in[REQ_DATA_LSB +: 8];
               next_cur_type  = next_req_type;
               if (next_req_type > TYPE_REG_W || next_req_type == TYPE_TAKE ||
                   (is_bus(next_req_type) && next_req_speed == SPEED_RSVD) ||
                   (next_req_type == TYPE_ISO && !cycle_seen)) begin
                  next_refused = 1'b1;
               end else if (next_req_type == TYPE_REG_R || next_req_type == TYPE_REG_W) begin
                  next_state = R_WAIT_IDLE;
               end else begin
                  next_state = R_WAIT_IDLE;
               end
            end else if (ack_needed_in && tick && ctl_d == CTL_RECEIVE &&
                         req_speed != SPEED_RSVD) begin
               next_cur_type = TYPE_TAKE;
               load_type     = TYPE_TAKE;
               shift_load    = 1'b1;
               next_hdr_bad  = 1'b0;
               next_state    = R_SEND;
            end
         end
         R_WAIT_IDLE: begin
            if (!shift_busy && (cur_type == TYPE_REG_R || cur_type == TYPE_REG_W)) begin
               shift_load = 1'b1;
               next_state = R_SEND;
            end else if (!shift_busy && tick && ctl_d == CTL_IDLE && idle_prev) begin
               shift_load = 1'b1;
               next_state = R_SEND;
               if (cur_type == TYPE_ISO) begin
                  next_cycle_seen = 1'b0;
               end
            end
         end
         R_SEND, R_WATCH: begin
            if (cur_type == TYPE_TAKE && header_bad_in) begin
               next_hdr_bad = 1'b1;
            end
            if (tick && ctl_d == CTL_RECEIVE && is_bus(cur_type) && cur_type != TYPE_TAKE) begin
               next_lost  = 1'b1;
               next_state = R_WAIT_IDLE;
            end else if (state == R_SEND && shift_done) begin
               next_state = is_bus(cur_type) ? R_WATCH : R_IDLE;
            end else if (state == R_WATCH && tick && ctl_d == CTL_GRANT) begin
               next_state = R_IDLE;
               if (cur_type == TYPE_TAKE && (hdr_bad || header_bad_in)) begin
                  next_block_cnt = RELEASE_CYCLES;
               end
            end
         end
         default: next_state = R_IDLE;
      endcase
      if (cycle_start_in) begin
         next_cycle_seen = 1'b1;
      end

      // Grant is withheld for the whole grant that follows a bad header
      next_bus_grant = tick ? (ctl_d == CTL_GRANT && !(cur_type == TYPE_TAKE && next_hdr_bad)) : bus_grant_out;

      // Status transfers on the low data lines, two bits per link clock
      next_st_shift   = st_shift;
      next_st_cnt     = st_cnt;
      next_phy_status = phy_status;
      next_rd_addr    = rd_addr;
      next_rd_data    = rd_data;
      if (tick) begin
         if (ctl_d == CTL_STATUS) begin
            if (st_cnt != ST_PAIRS_FULL) begin
               next_st_shift = {st_shift[13:0], dat_d[0], dat_d[1]};
               next_st_cnt   = st_cnt + 4'h1;
            end
         end else begin
            if (ctl_d == CTL_IDLE && st_cnt == ST_PAIRS_FULL) begin
               next_phy_status = rev4(st_shift[15:12]);
               next_rd_addr    = st_shift[11:8];
               next_rd_data    = st_shift[7:0];
               next_rd_valid   = 1'b1;
            end else if (ctl_d == CTL_IDLE && st_cnt >= ST_PAIRS_SHORT) begin
               next_phy_status = rev4(st_shift[{st_cnt[2:0], 1'b0} - 4'h1 -: 4]);
            end
            next_st_cnt = 4'h0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state          <= R_IDLE;
         req_type       <= TYPE_FAIR;
         req_speed      <= SPEED_100;
         req_addr       <= 4'h0;
         req_data       <= 8'h00;
         cur_type       <= TYPE_FAIR;
         cycle_seen     <= 1'b0;
         lost           <= 1'b0;
         refused        <= 1'b0;
         hdr_bad        <= 1'b0;
         idle_prev      <= 1'b0;
         block_cnt      <= 4'h0;
         bus_grant_out  <= 1'b0;
         tx_blocked_out <= 1'b0;
         phy_status     <= 4'h0;
         rd_addr        <= 4'h0;
         rd_data        <= 8'h00;
         rd_valid       <= 1'b0;
         st_shift       <= 16'h0000;
         st_cnt         <= 4'h0;
         prdata_out     <= 32'h0000_0000;
         pslverr_out    <= 1'b0;
         pready_out     <= 1'b0;
      end else begin
         state          <= next_state;
         req_type       <= next_req_type;
         req_speed      <= next_req_speed;
         req_addr       <= next_req_addr;
         req_data       <= next_req_data;
         cur_type       <= next_cur_type;
         cycle_seen     <= next_cycle_seen;
         lost           <= next_lost;
         refused        <= next_refused;
         hdr_bad        <= next_hdr_bad;
         idle_prev      <= next_idle_prev;
         block_cnt      <= next_block_cnt;
         bus_grant_out  <= next_bus_grant;
         tx_blocked_out <= (next_block_cnt != 4'h0);
         phy_status     <= next_phy_status;
         rd_addr        <= next_rd_addr;
         rd_data        <= next_rd_data;
         rd_valid       <= next_rd_valid;
         st_shift       <= next_st_shift;
         st_cnt         <= next_st_cnt;
         prdata_out     <= next_prdata;
         pslverr_out    <= next_pslverr;
         pready_out     <= 1'b1;
      end
   end

   fair_after_idle_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (shift_load && (load_type == TYPE_FAIR || load_type == TYPE_PRI)) |-> (idle_prev && ctl_d == CTL_IDLE))
      else $error("fair or priority request started too soon after idle");
   lost_request_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (state == R_WATCH && tick && ctl_d == CTL_RECEIVE && cur_type != TYPE_TAKE) |=> (lost && state == R_WAIT_IDLE))
      else $error("receive seen after a bus request but request not marked lost");
   iso_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (shift_load && load_type == TYPE_ISO) |-> cycle_seen)
      else $error("isochronous request issued without a cycle start");
   take_in_receive_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (shift_load && load_type == TYPE_TAKE) |-> ctl_d == CTL_RECEIVE)
      else $error("immediate take issued outside packet reception");
   no_reserved_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      shift_load |-> (load_type <= TYPE_REG_W && !(is_bus(load_type) && req_speed == SPEED_RSVD)))
      else $error("reserved type or speed code issued");
   release_wait_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $rose(tx_blocked_out) |-> (tx_blocked_out && !bus_grant_out) [*8] ##1 !tx_blocked_out)
      else $error("bad header hold-off not eight cycles long");
   status_short_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (tick && ctl_d == CTL_IDLE && st_cnt == ST_PAIRS_SHORT) |=> phy_status == rev4($past(st_shift[3:0])))
      else $error("short status transfer not captured");
   read_return_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (tick && ctl_d == CTL_IDLE && st_cnt == ST_PAIRS_FULL) |=> (rd_valid && rd_data == $past(st_shift[7:0])))
      else $error("register contents from status transfer not captured");
endmodule

// File: rtl/phy_link_pkg.sv
package phy_link_pkg;
   // Request type codes carried in request_type_field
   localparam logic [2:0] TYPE_TAKE  = 3'h0;
   localparam logic [2:0] TYPE_ISO   = 3'h1;
   localparam logic [2:0] TYPE_PRI   = 3'h2;
   localparam logic [2:0] TYPE_FAIR  = 3'h3;
   localparam logic [2:0] TYPE_REG_R = 3'h4;
   localparam logic [2:0] TYPE_REG_W = 3'h5;

   // Codes of request_speed_field
   localparam logic [1:0] SPEED_100  = 2'h0;
   localparam logic [1:0] SPEED_200  = 2'h1;
   localparam logic [1:0] SPEED_400  = 2'h2;
   localparam logic [1:0] SPEED_RSVD = 2'h3;

   // Values of control_pair driven by the physical layer
   localparam logic [1:0] CTL_IDLE    = 2'h0;
   localparam logic [1:0] CTL_STATUS  = 2'h1;
   localparam logic [1:0] CTL_RECEIVE = 2'h2;
   localparam logic [1:0] CTL_GRANT   = 2'h3;

   // Serial request framing
   localparam int         FRAME_W   = 17;
   localparam logic [4:0] LEN_BUS   = 5'h07;
   localparam logic [4:0] LEN_REG_R = 5'h09;
   localparam logic [4:0] LEN_REG_W = 5'h11;
   localparam logic       START_BIT = 1'b1;
   localparam logic       STOP_BIT  = 1'b0;

   // Status transfer: two bits per link clock
   localparam logic [3:0] ST_PAIRS_SHORT = 4'h2;
   localparam logic [3:0] ST_PAIRS_FULL  = 4'h8;

   // APB register map
   localparam int          APB_ADDR_W     = 12;
   localparam logic [11:0] OFS_REQUEST    = 12'h000;
   localparam logic [11:0] OFS_STATUS     = 12'h004;
   localparam logic [11:0] OFS_PHY_STATUS = 12'h008;
   localparam logic [11:0] OFS_READ_DATA  = 12'h00C;

   // Field positions of the request register
   localparam int REQ_TYPE_LSB  = 0;
   localparam int REQ_SPEED_LSB = 4;
   localparam int REQ_ADDR_LSB  = 8;
   localparam int REQ_DATA_LSB  = 16;

   // Bit positions of the status register
   localparam int STB_BUSY    = 0;
   localparam int STB_LOST    = 1;
   localparam int STB_REFUSED = 2;
   localparam int STB_CYCLE   = 3;
   localparam int STB_RDVALID = 4;

   // Release hold-off after a bad header, least time rounded up
   localparam int         CLK_PERIOD_NS  = 20;
   localparam int         RELEASE_WAIT_NS = 160;
   localparam logic [3:0] RELEASE_CYCLES =
      4'((RELEASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// File: rtl/link_request_shifter.sv
`timescale 1ns/1ps
module link_request_shifter (
   // Clock and reset
   input  wire logic                               sys_clk_in,
   input  wire logic                               rst_in,
   // Link clock edge enable
   input  wire logic                               tick_in,
   // Frame to send, left justified
   input  wire logic                               load_in,
   input  wire logic [phy_link_pkg::FRAME_W-1:0]   frame_in,
   input  wire logic [4:0]                         len_in,
   // Serial line and progress
   output logic                                    line_out,
   output logic                                    busy_out,
   output logic                                    done_out
);
   import phy_link_pkg::*;

   logic [FRAME_W-1:0] shreg;
   logic [FRAME_W-1:0] next_shreg;
   logic [4:0]         cnt;
   logic [4:0]         next_cnt;
   logic [4:0]         len_q;
   logic [4:0]         next_len_q;
   logic               next_line;
   logic               next_done;

   always_comb begin
      next_shreg = shreg;
      next_cnt   = cnt;
      next_len_q = len_q;
      next_line  = line_out;
      next_done  = 1'b0;
      if (load_in && cnt == 5'h00) begin
         next_shreg = frame_in;
         next_cnt   = len_in;
         next_len_q = len_in;
      end else if (tick_in) begin
         if (cnt != 5'h00) begin
            // One bit per link clock, first bit out is the start bit
            next_line  = shreg[FRAME_W-1];
            next_shreg = {shreg[FRAME_W-2:0], 1'b0};
            next_cnt   = cnt - 5'h01;
            next_done  = (cnt == 5'h01);
         end else begin
            next_line = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         shreg    <= '0;
         cnt      <= 5'h00;
         len_q    <= 5'h00;
         line_out <= 1'b0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         shreg    <= next_shreg;
         cnt      <= next_cnt;
         len_q    <= next_len_q;
         line_out <= next_line;
         busy_out <= (next_cnt != 5'h00);
         done_out <= next_done;
      end
   end

   start_bit_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (tick_in && cnt == len_q && cnt != 5'h00) |=> line_out == START_BIT)
      else $error("request stream did not open with a start bit");
   stop_bit_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (tick_in && cnt == 5'h01) |=> (line_out == STOP_BIT && done_out))
      else $error("request stream did not close with a stop bit");
   line_quiet_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (tick_in && cnt == 5'h00 && !load_in) |=> !line_out)
      else $error("request line high with no stream in progress");
endmodule

// File: testbench/phy_partner.sv
`timescale 1ns/1ps
module phy_partner (
   // From the link
   input  wire logic       line_in,
   // Phy-owned lines
   output logic            lclk_out,
   output logic [1:0]      ctl_out,
   output logic [1:0]      dat_out
);
   import phy_link_pkg::*;
   logic [16:0] sh;
   logic [4:0]  n;
   logic [4:0]  len;
   logic [2:0]  typ;
   logic        iso_pend;
   logic [7:0]  regs [16];
   int          frames;
   initial begin
      lclk_out = 1'b0;
      sh = '0;
      n = '0;
      len = '0;
      frames = 0;
      typ = '0;
      iso_pend = 1'b0;
      ctl_out = CTL_IDLE;
      dat_out = 2'h3;
   end
   always #80 lclk_out = ~lclk_out;
   // Length is known once the type bits are in
   always @(posedge lclk_out) if (n != 0 || line_in) begin
      sh = (n == 0) ? 17'h0_0001 : {sh[15:0], line_in};
      n = n + 5'h01;
      if (n == 5'h04) begin
         typ = sh[2:0];
         len = (sh[2:0] == TYPE_REG_W) ? LEN_REG_W : (sh[2:0] == TYPE_REG_R) ? LEN_REG_R : LEN_BUS;
      end
      if (n == len) begin
         n = '0;
         frames++;
         // Written data loads as soon as the stream is complete
         if (typ == TYPE_REG_W) regs[sh[12:9]] = sh[8:1];
         // A bus request of another type drops a pending isochronous one
         if (typ < TYPE_REG_R) iso_pend = (typ == TYPE_ISO);
      end
   end
   task automatic drive(input logic [1:0] c, input int k);
      repeat (k) begin
         @(negedge lclk_out);
         ctl_out = c;
         if (c == CTL_GRANT) iso_pend = 1'b0;
      end
   endtask
   // Status goes out on the low data lines only; a cut transfer is sent again whole
   task automatic status(input logic [15:0] b, input int k, input int cut);
      if (cut > 0) begin
         for (int i = 0; i < cut; i++) begin
            @(negedge lclk_out);
            ctl_out = CTL_STATUS;
            dat_out = b[2*i +: 2];
         end
         drive(CTL_RECEIVE, 3);
         drive(CTL_IDLE, 2);
      end
      for (int i = 0; i < k; i++) begin
         @(negedge lclk_out);
         ctl_out = CTL_STATUS;
         dat_out = b[2*i +: 2];
      end
      drive(CTL_IDLE, 2);
      dat_out = ~dat_out;
   endtask
endmodule

// File: testbench/tb_phy_link_request_status.sv
`timescale 1ns/1ps
module tb_phy_link_request_status;
   import phy_link_pkg::*;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, cst = 0, ack = 0, hbad = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic        pready, pslverr, line, lclk, grant, blocked, err;
   logic [1:0]  ctl, dat;
   logic [31:0] bad [5] = '{32'h0, 32'h6, 32'h7, 32'h33, 32'h1};
   int          fails = 0, total_checks = 0, cyc = 0, nb = 0, n0;
   always #10 clk = ~clk;
   phy_link_request_status phy_link_request_status_inst (.sys_clk_in(clk), .rst_in(rst), .paddr_in(paddr),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .link_clock_in(lclk), .control_pair_in(ctl),
      .low_data_lines_in(dat), .link_request_line_out(line), .cycle_start_in(cst), .ack_needed_in(ack),
      .header_bad_in(hbad), .bus_grant_out(grant), .tx_blocked_out(blocked));
   phy_partner phy_partner_inst (.line_in(line), .lclk_out(lclk), .ctl_out(ctl), .dat_out(dat));
   always @(posedge clk) nb <= nb + int'(blocked === 1'b1);
   function automatic logic [31:0] mk(input logic [2:0] t, input logic [1:0] s, input logic [3:0] a);
      return {8'h00, 8'h5c, 4'h0, a, 2'h0, s, 1'b0, t};
   endfunction
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value at %0t: %h, expected %h", $time, g, e);
      end
   endtask
   // Launch a request, then compare the whole stream the phy collected
   task automatic req(input logic [31:0] w, input logic [16:0] f, input logic [4:0] l);
      n0 = phy_partner_inst.frames;
      apb(1'b1, OFS_REQUEST, w);
      wait (phy_partner_inst.frames != n0);
      chk(32'(phy_partner_inst.sh), 32'(f));
      chk(32'(phy_partner_inst.len), 32'(l));
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         test_done();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      req(mk(TYPE_REG_W, 2'h0, 4'ha), {START_BIT, TYPE_REG_W, 4'ha, 8'h5c, STOP_BIT}, LEN_REG_W);
      chk(32'(phy_partner_inst.regs[4'ha]), 32'h0000_005c);
      repeat (20) @(posedge clk);
      chk({31'h0, line}, 32'h0);
      req(mk(TYPE_REG_R, 2'h0, 4'h3), {8'h00, START_BIT, TYPE_REG_R, 4'h3, STOP_BIT}, LEN_REG_R);
      phy_partner_inst.status(16'h69c5, 8, 5);
      repeat (10) @(posedge clk);
      apb(1'b0, OFS_READ_DATA, '0);
      chk(q, 32'h0000_0396);
      apb(1'b0, OFS_PHY_STATUS, '0);
      chk(q, 32'h0000_0005);
      phy_partner_inst.status(16'h000a, 3, 0);
      repeat (10) @(posedge clk);
      apb(1'b0, OFS_PHY_STATUS, '0);
      chk(q, 32'h0000_000a);
      for (int i = 0; i < 3; i++) begin
         req(mk(TYPE_PRI + 3'(i % 2), 2'(i), 4'h0), {10'h000, START_BIT, TYPE_PRI + 3'(i % 2), 2'(i), STOP_BIT}, LEN_BUS);
         phy_partner_inst.drive(CTL_GRANT, 3);
         chk({31'h0, grant}, 32'h1);
         phy_partner_inst.drive(CTL_IDLE, 2);
      end
      foreach (bad[i]) begin
         n0 = phy_partner_inst.frames;
         apb(1'b1, OFS_STATUS, 32'h0000_0004);
         apb(1'b1, OFS_REQUEST, bad[i]);
         repeat (120) @(posedge clk);
         apb(1'b0, OFS_STATUS, '0);
         chk(q & 32'h0000_0005, 32'h0000_0004);
         chk(32'(phy_partner_inst.frames - n0), 32'h0);
      end
      cst <= 1'b1;
      @(posedge clk);
      cst <= 1'b0;
      req(mk(TYPE_ISO, 2'h1, 4'h0), {10'h000, START_BIT, TYPE_ISO, 2'h1, STOP_BIT}, LEN_BUS);
      chk(32'(phy_partner_inst.iso_pend), 32'h1);
      phy_partner_inst.drive(CTL_GRANT, 3);
      phy_partner_inst.drive(CTL_IDLE, 2);
      req(mk(TYPE_FAIR, 2'h1, 4'h0), {10'h000, START_BIT, TYPE_FAIR, 2'h1, STOP_BIT}, LEN_BUS);
      n0 = phy_partner_inst.frames;
      phy_partner_inst.drive(CTL_RECEIVE, 2);
      apb(1'b0, OFS_STATUS, '0);
      chk(q & 32'h0000_0002, 32'h0000_0002);
      phy_partner_inst.drive(CTL_IDLE, 2);
      wait (phy_partner_inst.frames != n0);
      chk(32'(phy_partner_inst.sh), {25'h0, START_BIT, TYPE_FAIR, 2'h1, STOP_BIT});
      phy_partner_inst.drive(CTL_GRANT, 3);
      phy_partner_inst.drive(CTL_IDLE, 2);
      @(posedge clk);
      ack <= 1'b1;
      hbad <= 1'b1;
      phy_partner_inst.drive(CTL_RECEIVE, 12);
      chk(32'(phy_partner_inst.sh), {25'h0, START_BIT, TYPE_TAKE, 2'h1, STOP_BIT});
      phy_partner_inst.drive(CTL_GRANT, 3);
      chk({31'h0, grant}, 32'h0);
      @(posedge clk);
      ack <= 1'b0;
      phy_partner_inst.drive(CTL_IDLE, 2);
      chk(32'(nb), 32'h8);
      chk({31'h0, grant}, 32'h0);
      apb(1'b0, 12'h010, '0);
      chk({31'h0, err}, 32'h1);
      test_done();
   end
endmodule
